// *** verilog/pfr_pkg.sv ***
package pfr_pkg;

  // Register byte offsets
  localparam logic [8:0] OFS_ANT_LEVEL = 9'h12C;
  localparam logic [8:0] OFS_THRESH_DIFF = 9'h12D;
  localparam logic [8:0] OFS_PRE_LOW = 9'h12E;
  localparam logic [8:0] OFS_PRE_HIGH = 9'h12F;
  localparam logic [8:0] OFS_SFD_LOW = 9'h130;
  localparam logic [8:0] OFS_SFD_HIGH = 9'h131;
  localparam logic [8:0] OFS_HDR_FLAGS = 9'h132;
  localparam logic [8:0] OFS_HDR_LEN = 9'h133;
  localparam logic [8:0] OFS_RX_SIGNAL = 9'h134;
  localparam logic [8:0] OFS_RX_SIZE = 9'h135;
  localparam logic [8:0] OFS_TX_SIGNAL = 9'h136;
  localparam logic [8:0] OFS_TX_SIZE = 9'h137;
  localparam logic [8:0] OFS_RX_PTR = 9'h13D;
  localparam logic [8:0] OFS_TX_PTR = 9'h13E;
  localparam logic [8:0] OFS_RX_BASE = 9'h140;
  localparam logic [8:0] OFS_TX_BASE = 9'h141;

  // Header field positions
  localparam int HDR_MODE_BIT = 7;
  localparam int HDR_FCS_BIT = 4;
  localparam int HDR_WHITEN_BIT = 3;
  localparam logic [7:0] HDR_RSVD_MASK = 8'h9F;

  // Level scale, preamble limits and reset value
  localparam logic [7:0] LEVEL_OFFSET = 8'h6B;
  localparam logic [15:0] PRE_MIN = 16'h0004;
  localparam logic [15:0] PRE_MAX = 16'h03E8;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_HDR0 = 4'b0010,
    TX_HDR1 = 4'b0100,
    TX_RUN = 4'b1000
  } pfr_tx_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pfr_bus_req_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } pfr_mem_wr_t;

  typedef struct packed {
    logic [7:0] antLevel;
    logic [7:0] threshDiff;
    logic [7:0] preLow;
    logic [7:0] preHigh;
    logic [7:0] sfdLow;
    logic [7:0] sfdHigh;
    logic [7:0] hdrFlags;
    logic [7:0] hdrLen;
    logic [7:0] rxSignal;
    logic [7:0] rxSize;
    logic [7:0] txSignal;
    logic [7:0] txSize;
    logic [7:0] rxBase;
    logic [7:0] txBase;
    logic [7:0] rxPtr;
    logic [7:0] txPtr;
    pfr_tx_state_t txState;
    logic txPend;
    logic [7:0] rdData;
    logic preOk;
    pfr_mem_wr_t memWr;
    logic [7:0] memRdAddr;
    logic txValid;
    logic [7:0] txByte;
    logic almostFull;
    logic full;
    logic crcCorrect;
    logic rxEof;
  } pfr_state_t;

endpackage : pfr_pkg

// *** verilog/pfr_frame_buffer.sv ***
`timescale 1ns/1ps

// What this block does
// - Store second antenna level as dBm plus 107
// - Hold threshold minus latest evaluated level
// - Preamble count 16 bits, valid 4..1000
// - Delimiter word from low and high bytes
// - Receive copies both header bytes into registers
// - Transmit mirrors header from transmit base location
// - Flags bit 7 mode switch, bits 6:5 zero
// - Flags bit 4: 0 long check, 1 short
// - Long check never raises correct check event
// - Flags bit 3 marks whitened payload
// - Payload length 11 bits, between 2 and 2047; the block does not check the range, so 0 and 1 pass
// - Receive fill at signal offset raises almost full
// - Receive fill at size raises full, wraps
// - Transmit send at signal offset raises almost full
// - Transmit send at size raises full, wraps
module pfr_frame_buffer (
  input wire logic mclk,
  input wire logic reset,
  input wire pfr_pkg::pfr_bus_req_t busReq,
  output logic [7:0] readData,
  input wire logic [7:0] clearChannelThreshold,
  input wire logic rssiValid,
  input wire logic rssiAntenna,
  input wire logic [7:0] rssiDbm,
  input wire logic rxFrameStart,
  input wire logic rxHdrValid,
  input wire logic [7:0] rxHdrFlags,
  input wire logic [7:0] rxHdrLength,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic crcOkIn,
  input wire logic rxEofIn,
  input wire logic txStart,
  input wire logic txStop,
  input wire logic txByteReq,
  input wire logic [7:0] memRdData,
  output pfr_pkg::pfr_mem_wr_t memWr,
  output logic [7:0] memRdAddr,
  output logic txByteValid,
  output logic [7:0] txByte,
  output logic [15:0] preambleByteCount,
  output logic preambleCountOk,
  output logic [15:0] frameDelimiter,
  output logic modeSwitch,
  output logic fcsShort,
  output logic whitened,
  output logic [10:0] payloadLength,
  output logic bufferAlmostFull,
  output logic bufferFull,
  output logic crcCorrect,
  output logic rxEndOfFrame
);

  pfr_pkg::pfr_state_t s_q;
  pfr_pkg::pfr_state_t s_d;
  logic [7:0] rxPos;
  logic [15:0] preCount;

  assign preCount = {s_q.preHigh, s_q.preLow};

  always_comb
  begin
    s_d = s_q;
    s_d.rdData = pfr_pkg::REG_RESET;
    s_d.memWr.we = 1'b0;
    s_d.txValid = 1'b0;
    s_d.almostFull = 1'b0;
    s_d.full = 1'b0;
    s_d.crcCorrect = 1'b0;
    s_d.rxEof = 1'b0;
    rxPos = rxFrameStart ? 8'h00 : s_q.rxPtr;

    // Host writes; header bytes are read only and ignore writes
    if (busReq.wr)
    begin
      case (busReq.addr)
        pfr_pkg::OFS_ANT_LEVEL: s_d.antLevel = busReq.wdata;
        pfr_pkg::OFS_THRESH_DIFF: s_d.threshDiff = busReq.wdata;
        pfr_pkg::OFS_PRE_LOW: s_d.preLow = busReq.wdata;
        pfr_pkg::OFS_PRE_HIGH: s_d.preHigh = busReq.wdata;
        pfr_pkg::OFS_SFD_LOW: s_d.sfdLow = busReq.wdata;
        pfr_pkg::OFS_SFD_HIGH: s_d.sfdHigh = busReq.wdata;
        pfr_pkg::OFS_RX_SIGNAL: s_d.rxSignal = busReq.wdata;
        pfr_pkg::OFS_RX_SIZE: s_d.rxSize = busReq.wdata;
        pfr_pkg::OFS_TX_SIGNAL: s_d.txSignal = busReq.wdata;
        pfr_pkg::OFS_TX_SIZE: s_d.txSize = busReq.wdata;
        pfr_pkg::OFS_RX_BASE: s_d.rxBase = busReq.wdata;
        pfr_pkg::OFS_TX_BASE: s_d.txBase = busReq.wdata;
        default: ;
      endcase
    end

    // Unmapped reads return zero
    if (busReq.rd)
    begin
      case (busReq.addr)
        pfr_pkg::OFS_ANT_LEVEL: s_d.rdData = s_q.antLevel;
        pfr_pkg::OFS_THRESH_DIFF: s_d.rdData = s_q.threshDiff;
        pfr_pkg::OFS_PRE_LOW: s_d.rdData = s_q.preLow;
        pfr_pkg::OFS_PRE_HIGH: s_d.rdData = s_q.preHigh;
        pfr_pkg::OFS_SFD_LOW: s_d.rdData = s_q.sfdLow;
        pfr_pkg::OFS_SFD_HIGH: s_d.rdData = s_q.sfdHigh;
        pfr_pkg::OFS_HDR_FLAGS: s_d.rdData = s_q.hdrFlags;
        pfr_pkg::OFS_HDR_LEN: s_d.rdData = s_q.hdrLen;
        pfr_pkg::OFS_RX_SIGNAL: s_d.rdData = s_q.rxSignal;
        pfr_pkg::OFS_RX_SIZE: s_d.rdData = s_q.rxSize;
        pfr_pkg::OFS_TX_SIGNAL: s_d.rdData = s_q.txSignal;
        pfr_pkg::OFS_TX_SIZE: s_d.rdData = s_q.txSize;
        pfr_pkg::OFS_RX_PTR: s_d.rdData = s_q.rxPtr;
        pfr_pkg::OFS_TX_PTR: s_d.rdData = s_q.txPtr;
        pfr_pkg::OFS_RX_BASE: s_d.rdData = s_q.rxBase;
        pfr_pkg::OFS_TX_BASE: s_d.rdData = s_q.txBase;
        default: s_d.rdData = pfr_pkg::REG_RESET;
      endcase
    end

    // Measurements override a host write in the same cycle
    if (rssiValid)
    begin
      if (rssiAntenna)
      begin
        s_d.antLevel = rssiDbm + pfr_pkg::LEVEL_OFFSET;
      end
      s_d.threshDiff = clearChannelThreshold - (rssiDbm + pfr_pkg::LEVEL_OFFSET);
    end

    s_d.preOk = (preCount >= pfr_pkg::PRE_MIN) && (preCount <= pfr_pkg::PRE_MAX);

    if (rxHdrValid)
    begin
      s_d.hdrFlags = rxHdrFlags & pfr_pkg::HDR_RSVD_MASK;
      s_d.hdrLen = rxHdrLength;
    end

    // Receive fill; a frame start restarts at the base
    if (rxFrameStart)
    begin
      s_d.rxPtr = 8'h00;
    end
    if (rxByteValid)
    begin
      s_d.memWr.we = 1'b1;
      s_d.memWr.addr = s_q.rxBase + rxPos;
      s_d.memWr.data = rxByte;
      s_d.almostFull = (rxPos == s_q.rxSignal);
      if (rxPos == s_q.rxSize)
      begin
        s_d.full = 1'b1;
        s_d.rxPtr = 8'h00;
      end
      else
      begin
        s_d.rxPtr = rxPos + 8'h01;
      end
    end

    // Short check only; long check is left to the host
    s_d.crcCorrect = crcOkIn && s_q.hdrFlags[pfr_pkg::HDR_FCS_BIT];
    s_d.rxEof = rxEofIn;

    // Transmit: header read back from base, then rolling send
    unique case (s_q.txState)
      pfr_pkg::TX_IDLE:
      begin
        if (txStart)
        begin
          s_d.memRdAddr = s_q.txBase;
          s_d.txState = pfr_pkg::TX_HDR0;
        end
      end
      pfr_pkg::TX_HDR0:
      begin
        s_d.hdrFlags = memRdData & pfr_pkg::HDR_RSVD_MASK;
        s_d.memRdAddr = s_q.txBase + 8'h01;
        s_d.txState = pfr_pkg::TX_HDR1;
      end
      pfr_pkg::TX_HDR1:
      begin
        s_d.hdrLen = memRdData;
        s_d.txPtr = 8'h00;
        s_d.txPend = 1'b0;
        s_d.txState = pfr_pkg::TX_RUN;
      end
      pfr_pkg::TX_RUN:
      begin
        if (txStop)
        begin
          s_d.txPend = 1'b0;
          s_d.txState = pfr_pkg::TX_IDLE;
        end
        else if (s_q.txPend)
        begin
          // A request during the fetch is dropped; one byte in flight
          s_d.txByte = memRdData;
          s_d.txValid = 1'b1;
          s_d.txPend = 1'b0;
        end
        else if (txByteReq)
        begin
          s_d.memRdAddr = s_q.txBase + s_q.txPtr;
          s_d.txPend = 1'b1;
          s_d.almostFull = s_d.almostFull || (s_q.txPtr == s_q.txSignal);
          if (s_q.txPtr == s_q.txSize)
          begin
            s_d.full = 1'b1;
            s_d.txPtr = 8'h00;
          end
          else
          begin
            s_d.txPtr = s_q.txPtr + 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.txState <= pfr_pkg::TX_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign readData = s_q.rdData;
  assign memWr = s_q.memWr;
  assign memRdAddr = s_q.memRdAddr;
  assign txByteValid = s_q.txValid;
  assign txByte = s_q.txByte;
  assign preambleByteCount = preCount;
  assign preambleCountOk = s_q.preOk;
  assign frameDelimiter = {s_q.sfdHigh, s_q.sfdLow};
  assign modeSwitch = s_q.hdrFlags[pfr_pkg::HDR_MODE_BIT];
  assign fcsShort = s_q.hdrFlags[pfr_pkg::HDR_FCS_BIT];
  assign whitened = s_q.hdrFlags[pfr_pkg::HDR_WHITEN_BIT];
  assign payloadLength = {s_q.hdrFlags[2:0], s_q.hdrLen};
  assign bufferAlmostFull = s_q.almostFull;
  assign bufferFull = s_q.full;
  assign crcCorrect = s_q.crcCorrect;
  assign rxEndOfFrame = s_q.rxEof;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [7:0] readAnt;
  assign readAnt = s_q.antLevel;

  property p_level_store;
    rssiValid && rssiAntenna |=> readAnt == ($past(rssiDbm) + 8'h6B);
  endproperty
  a_level_store: assert property (p_level_store)
    else $error("Antenna level not stored as dBm plus 107");

  property p_thresh_diff;
    rssiValid |=> s_q.threshDiff == $past(clearChannelThreshold) - ($past(rssiDbm) + 8'h6B);
  endproperty
  a_thresh_diff: assert property (p_thresh_diff)
    else $error("Threshold difference wrong");

  property p_preamble_ok;
    ##1 preambleCountOk == ($past(preambleByteCount) >= 16'h0004
      && $past(preambleByteCount) <= 16'h03E8);
  endproperty
  a_preamble_ok: assert property (p_preamble_ok)
    else $error("Preamble range flag wrong");

  property p_sfd_high;
    busReq.wr && busReq.addr == 9'h131 |=> frameDelimiter[15:8] == $past(busReq.wdata);
  endproperty
  a_sfd_high: assert property (p_sfd_high)
    else $error("Delimiter high byte not taken");

  property p_rx_header;
    rxHdrValid |=> payloadLength == {$past(rxHdrFlags[2:0]), $past(rxHdrLength)}
      && fcsShort == $past(rxHdrFlags[4]);
  endproperty
  a_rx_header: assert property (p_rx_header)
    else $error("Received header not copied");

  property p_reserved_zero;
    s_q.hdrFlags[6:5] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved header bits not zero");

  property p_tx_mirror;
    s_q.txState == pfr_pkg::TX_HDR1 |=> s_q.hdrLen == $past(memRdData)
      && s_q.txState == pfr_pkg::TX_RUN;
  endproperty
  a_tx_mirror: assert property (p_tx_mirror)
    else $error("Transmit header not mirrored");

  property p_long_check;
    !fcsShort && !rxHdrValid && s_q.txState != pfr_pkg::TX_HDR0 |=> !crcCorrect;
  endproperty
  a_long_check: assert property (p_long_check)
    else $error("Correct check event with long check");

  property p_rx_almost;
    rxByteValid && !rxFrameStart && s_q.rxPtr == s_q.rxSignal |=> bufferAlmostFull
      && memWr.we && memWr.addr == $past(s_q.rxBase) + $past(s_q.rxSignal);
  endproperty
  a_rx_almost: assert property (p_rx_almost)
    else $error("Receive almost full missed");

  property p_rx_wrap;
    rxByteValid && !rxFrameStart && s_q.rxPtr == s_q.rxSize |=> bufferFull
      && s_q.rxPtr == 8'h00;
  endproperty
  a_rx_wrap: assert property (p_rx_wrap)
    else $error("Receive full or wrap missed");

  property p_tx_send;
    s_q.txState == pfr_pkg::TX_RUN && !txStop && !s_q.txPend && txByteReq
      |=> memRdAddr == $past(s_q.txBase) + $past(s_q.txPtr) ##1 txByteValid;
  endproperty
  a_tx_send: assert property (p_tx_send)
    else $error("Transmit fetch or delivery wrong");

  property p_tx_wrap;
    s_q.txState == pfr_pkg::TX_RUN && !txStop && !s_q.txPend && txByteReq
      && s_q.txPtr == s_q.txSize |=> bufferFull && s_q.txPtr == 8'h00;
  endproperty
  a_tx_wrap: assert property (p_tx_wrap)
    else $error("Transmit full or wrap missed");

  c_rx_wrap: cover property (rxByteValid && s_q.rxPtr == s_q.rxSize ##1 bufferFull);
  c_tx_header: cover property (txStart ##3 s_q.txState == pfr_pkg::TX_RUN);
  c_tx_byte: cover property (txByteReq ##2 txByteValid);
  c_crc_short: cover property (crcOkIn && fcsShort ##1 crcCorrect);

endmodule : pfr_frame_buffer

// *** sim/pfr_pkt_mem.sv ***
`timescale 1ns/1ps

// Packet memory on the far side of the framer; reads are combinational
module pfr_pkt_mem (
  input wire logic mclk,
  input wire pfr_pkg::pfr_mem_wr_t memWr,
  input wire logic [7:0] memRdAddr,
  output logic [7:0] memRdData
);
  // Full 256 bytes, so two overflow bytes past any wrap point exist
  logic [7:0] mem [256];

  always_ff @(posedge mclk)
  begin
    if (memWr.we)
      mem[memWr.addr] <= memWr.data;
  end

  // Unwritten cells read as unknown, so a stray fetch cannot pass by luck
  assign memRdData = mem[memRdAddr];
endmodule : pfr_pkt_mem

// *** sim/pfr_frame_buffer_tb_top.sv ***
`timescale 1ns/1ps

module pfr_frame_buffer_tb_top;
  logic mclk = 0;
  logic reset = 1;
  pfr_pkg::pfr_bus_req_t busReq = '0;
  pfr_pkg::pfr_mem_wr_t memWr;
  logic [7:0] clearChannelThreshold = 0, rssiDbm = 0, rxHdrFlags = 0, rxHdrLength = 0;
  logic [7:0] rxByte = 0, readData, memRdData, memRdAddr, txByte, v, w, p, lv;
  logic rssiValid = 0, rssiAntenna = 0, rxFrameStart = 0, rxHdrValid = 0, rxByteValid = 0;
  logic crcOkIn = 0, rxEofIn = 0, txStart = 0, txStop = 0, txByteReq = 0, rdLast = 0;
  logic txByteValid, preambleCountOk, modeSwitch, fcsShort, whitened;
  logic bufferAlmostFull, bufferFull, crcCorrect, rxEndOfFrame;
  logic [15:0] preambleByteCount, frameDelimiter;
  logic [10:0] payloadLength;
  logic [3:0] ev;
  logic [31:0] seed = 32'h08e0_e41f;
  logic [23:0] rdQ[$], wrQ[$], txQ[$], evQ[$];
  logic [8:0] adr [14] = '{9'h12C, 9'h12D, 9'h12E, 9'h12F, 9'h130, 9'h131, 9'h134, 9'h135,
    9'h136, 9'h137, 9'h140, 9'h132, 9'h133, 9'h1FF};
  logic [15:0] pre [4] = '{16'h0003, 16'h0004, 16'h03E8, 16'h03E9};
  int errors = 0;
  int check_count = 0;

  pfr_frame_buffer u_dut (.mclk, .reset, .busReq, .readData, .clearChannelThreshold,
    .rssiValid, .rssiAntenna, .rssiDbm, .rxFrameStart, .rxHdrValid, .rxHdrFlags,
    .rxHdrLength, .rxByteValid, .rxByte, .crcOkIn, .rxEofIn, .txStart, .txStop,
    .txByteReq, .memRdData, .memWr, .memRdAddr, .txByteValid, .txByte,
    .preambleByteCount, .preambleCountOk, .frameDelimiter, .modeSwitch, .fcsShort,
    .whitened, .payloadLength, .bufferAlmostFull, .bufferFull, .crcCorrect, .rxEndOfFrame);

  pfr_pkt_mem u_mem (.mclk, .memWr, .memRdAddr, .memRdData);

  assign ev = {bufferAlmostFull, bufferFull, crcCorrect, rxEndOfFrame};

  always #10 mclk = ~mclk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task chk_rd(input logic [23:0] got, input logic [23:0] exp);
    chk(got, exp);
  endtask : chk_rd

  task chk_mem(input logic [23:0] got, input logic [23:0] exp);
    chk(got, exp);
  endtask : chk_mem

  task chk_tx(input logic [23:0] got, input logic [23:0] exp);
    chk(got, exp);
  endtask : chk_tx

  task chk_ev(input logic [23:0] got, input logic [23:0] exp);
    chk(got, exp);
  endtask : chk_ev

  task chk_out(input logic [23:0] got, input logic [23:0] exp);
    chk(got, exp);
  endtask : chk_out

  task end_sim();
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // Strobes are dropped here, and busReq and txByteReq also inline after a clock, so no signal is assigned twice in one step
  task idle(input int n);
    busReq <= '0;
    {rssiValid, rxFrameStart, rxHdrValid, rxByteValid} <= '0;
    {crcOkIn, rxEofIn, txStart, txStop, txByteReq} <= '0;
    repeat (n) @(posedge mclk);
  endtask : idle

  task wr(input logic [8:0] a, input logic [7:0] d);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
  endtask : wr

  task rd(input logic [8:0] a, input logic [7:0] e);
    rdQ.push_back({16'h0000, e});
    busReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
  endtask : rd

  // Results are matched against the oldest note; an empty queue yields unknown
  always @(posedge mclk)
  begin
    if (!reset)
      chk_rd(readData, rdLast ? (rdQ.size() ? rdQ.pop_front() : 'x) : 24'h00_0000);
    rdLast = busReq.rd;
    if (memWr.we)
      chk_mem({memWr.addr, memWr.data}, wrQ.size() ? wrQ.pop_front() : 'x);
    if (txByteValid)
      chk_tx(txByte, txQ.size() ? txQ.pop_front() : 'x);
    if (|ev)
      chk_ev(ev, evQ.size() ? evQ.pop_front() : 'x);
  end

  initial
  begin
    repeat (3000) @(posedge mclk);
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    for (int i = 0; i < 14; i++)
    begin
      v = rnd();
      rd(adr[i], 8'h00);
      wr(adr[i], v);
      rd(adr[i], i < 11 ? v : 8'h00);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      w = rnd();
      wr(9'h12E, pre[i][7:0]);
      wr(9'h12F, pre[i][15:8]);
      wr(9'h130, w);
      wr(9'h131, v);
      idle(2);
      chk_out(preambleByteCount, pre[i]);
      chk_out(preambleCountOk, pre[i] >= 16'h0004 && pre[i] <= 16'h03E8);
      chk_out(frameDelimiter, {v, w});
    end
    for (int i = 0; i < 3; i++)
    begin
      v = rnd();
      w = rnd();
      // The middle pass measures the first antenna, so the stored level must hold
      rssiValid <= 1;
      rssiAntenna <= (i != 1);
      rssiDbm <= v;
      clearChannelThreshold <= w;
      if (i != 1)
        lv = v + 8'h6B;
      @(posedge mclk);
      idle(1);
      rd(9'h12C, lv);
      rd(9'h12D, w - (v + 8'h6B));
      idle(1);
    end
    for (int i = 0; i < 2; i++)
    begin
      v = rnd();
      v[4] = i[0];
      w = rnd();
      w[7] = 1'b1;
      rxHdrFlags <= v;
      rxHdrLength <= w;
      rxHdrValid <= 1;
      @(posedge mclk);
      idle(1);
      chk_out({modeSwitch, fcsShort, whitened}, {v[7], v[4], v[3]});
      chk_out(payloadLength, {v[2:0], w});
      rd(9'h132, v & 8'h9F);
      rd(9'h133, w);
      // Drop the read strobe, or the last read would repeat unannounced
      busReq <= '0;
      crcOkIn <= 1;
      rxEofIn <= 1;
      evQ.push_back({2'b00, v[4], 1'b1});
      @(posedge mclk);
      idle(3);
    end
    // Offsets above 2 as the host must program them; wrap after offset 5
    wr(9'h140, 8'h20);
    wr(9'h134, 8'h03);
    wr(9'h135, 8'h05);
    idle(1);
    for (int i = 0; i < 8; i++)
    begin
      p = 8'(i % 6);
      v = rnd();
      rxFrameStart <= (i == 0);
      rxByteValid <= 1;
      rxByte <= v;
      wrQ.push_back({8'h00, 8'h20 + p, v});
      if (p == 3)
        evQ.push_back(24'h00_0008);
      if (p == 5)
        evQ.push_back(24'h00_0004);
      @(posedge mclk);
    end
    idle(3);
    for (int k = 0; k < 8; k++)
      u_mem.mem[8'h80 + 8'(k)] = rnd();
    wr(9'h141, 8'h80);
    wr(9'h136, 8'h03);
    wr(9'h137, 8'h04);
    idle(1);
    txStart <= 1;
    @(posedge mclk);
    idle(4);
    rd(9'h132, u_mem.mem[8'h80] & 8'h9F);
    rd(9'h133, u_mem.mem[8'h81]);
    idle(1);
    for (int i = 0; i < 7; i++)
    begin
      p = 8'(i % 5);
      txByteReq <= 1;
      txQ.push_back({16'h0000, u_mem.mem[8'h80 + p]});
      if (p == 3)
        evQ.push_back(24'h00_0008);
      if (p == 4)
        evQ.push_back(24'h00_0004);
      @(posedge mclk);
      txByteReq <= 0;
      @(posedge mclk);
    end
    idle(2);
    rd(9'h13D, 8'h02);
    rd(9'h13E, 8'h02);
    idle(1);
    txStop <= 1;
    @(posedge mclk);
    idle(5);
    chk_out(24'(rdQ.size() + wrQ.size() + txQ.size() + evQ.size()), 24'h00_0000);
    end_sim();
  end
endmodule : pfr_frame_buffer_tb_top
